// File: verilog/pll_config_register_bank.v
`timescale 1ns/100ps
`include "pll_cfg_regs.vh"
module pll_config_register_bank #(
  parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
  input wire clk,
  input wire rstn,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  output wire [15:0] spread_step_size,
  output wire [7:0] spread_step_delta,
  output wire [9:0] spread_period,
  output wire spread_modulation_on,
  output wire filter_res_100k_add,
  output wire filter_res_50k_add,
  output wire filter_res_25k_add,
  output wire filter_res_12k5_add,
  output wire filter_res_6k_only,
  output wire pump_gain_x16,
  output wire pump_gain_x8,
  output wire pump_gain_x4,
  output wire pump_gain_x2,
  output wire pump_gain_x1,
  output wire pump_scale_div24,
  output wire pump_scale_div3,
  output wire reference_current_select,
  output wire reference_doubler_on,
  output wire reference_bypass_by_one,
  output wire reference_bypass_by_two,
  output wire [4:0] reference_divide_value,
  output wire [3:0] third_output_divide,
  output wire [3:0] fourth_output_divide,
  output wire fine_spread_resolution,
  output wire second_synth_ref_source,
  output wire third_synth_run,
  output wire second_synth_run,
  output wire first_synth_run,
  output wire third_synth_lock_use,
  output wire second_synth_lock_use,
  output wire first_synth_lock_use
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_WR = 3'h2;
  localparam [2:0] ST_ACK = 3'h3;
  localparam [2:0] ST_RD = 3'h4;
  localparam [2:0] ST_RACK = 3'h5;
  localparam [2:0] ST_WAIT = 3'h6;

  function in_bank;
    input [7:0] ofs;
    begin
      in_bank = (ofs >= `OFS_STEP_LOW) && (ofs <= `OFS_SYNTH_OP);
    end
  endfunction

  function [7:0] reset_value;
    input integer idx;
    begin
      case (idx)
        4'h0: reset_value = `RST_STEP_LOW;
        4'h1: reset_value = `RST_STEP_DELTA;
        4'h2: reset_value = `RST_STEP_HIGH;
        4'h3: reset_value = `RST_PERIOD_LOW;
        4'h4: reset_value = `RST_PERIOD_HIGH_FILTER;
        4'h5: reset_value = `RST_PUMP;
        4'h6: reset_value = `RST_REF_DIV;
        4'h7: reset_value = `RST_OUT_DIV;
        4'h8: reset_value = `RST_SYNTH_OP;
        default: reset_value = 8'h00;
      endcase
    end
  endfunction

  reg scl_q1_r, scl_q2_r, scl_q3_r;
  reg sda_q1_r, sda_q2_r, sda_q3_r;
  reg [2:0] state_r;
  reg [2:0] cnt_r;
  reg [7:0] shift_r;
  reg [7:0] tx_r;
  reg [7:0] ptr_r;
  reg ptr_ok_r;
  reg byte_r;
  reg is_read_r;
  reg sda_oe_r;
  reg sda_out_r;
  reg wr_en_r;
  reg [3:0] wr_idx_r;
  reg [7:0] wr_data_r;
  reg [7:0] bank_r [0:`REG_COUNT-1];

  wire scl_rise = scl_q2_r & ~scl_q3_r;
  wire scl_fall = ~scl_q2_r & scl_q3_r;
  wire bus_start = scl_q2_r & scl_q3_r & sda_q3_r & ~sda_q2_r;
  wire bus_stop = scl_q2_r & scl_q3_r & ~sda_q3_r & sda_q2_r;
  wire [7:0] ptr_idx = ptr_r - `OFS_STEP_LOW;
  // Unmapped offsets read as zero so a host scan stays harmless
  wire [7:0] rd_now = in_bank(ptr_r) ? bank_r[ptr_idx[3:0]] : 8'h00;

  // First stage feeds only the second; third stage is for edge finding
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q1_r <= 1'b1;
      scl_q2_r <= 1'b1;
      scl_q3_r <= 1'b1;
      sda_q1_r <= 1'b1;
      sda_q2_r <= 1'b1;
      sda_q3_r <= 1'b1;
    end else begin
      scl_q1_r <= scl_in;
      scl_q2_r <= scl_q1_r;
      scl_q3_r <= scl_q2_r;
      sda_q1_r <= sda_in;
      sda_q2_r <= sda_q1_r;
      sda_q3_r <= sda_q2_r;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      ptr_ok_r <= 1'b0;
      byte_r <= 1'b0;
      is_read_r <= 1'b0;
      sda_oe_r <= 1'b0;
      sda_out_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_idx_r <= 4'h0;
      wr_data_r <= 8'h00;
    end else begin
      wr_en_r <= 1'b0;
      if (bus_start) begin
        // Pointer survives a repeated start so a read follows a pointer write
        state_r <= ST_ADDR;
        cnt_r <= 3'h0;
        byte_r <= 1'b0;
        ptr_ok_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else if (bus_stop) begin
        state_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else if (scl_rise) begin
        case (state_r)
          ST_ADDR, ST_WR: begin
            shift_r <= {shift_r[6:0], sda_q2_r};
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
              byte_r <= 1'b1;
            end
          end
          ST_RD: begin
            cnt_r <= cnt_r + 3'h1;
          end
          ST_RACK: begin
            is_read_r <= ~sda_q2_r;
          end
          default: begin
            cnt_r <= cnt_r;
          end
        endcase
      end else if (scl_fall) begin
        case (state_r)
          ST_ADDR: begin
            if (byte_r) begin
              byte_r <= 1'b0;
              if (shift_r[7:1] == DEV_ADDR) begin
                is_read_r <= shift_r[0];
                sda_oe_r <= 1'b1;
                state_r <= ST_ACK;
              end else begin
                state_r <= ST_WAIT;
              end
            end
          end
          ST_WR: begin
            if (byte_r) begin
              byte_r <= 1'b0;
              sda_oe_r <= 1'b1;
              state_r <= ST_ACK;
              if (!ptr_ok_r) begin
                ptr_r <= shift_r;
                ptr_ok_r <= 1'b1;
              end else begin
                // Writes outside the bank are acknowledged and dropped
                wr_en_r <= in_bank(ptr_r);
                wr_idx_r <= ptr_idx[3:0];
                wr_data_r <= shift_r;
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          ST_ACK: begin
            cnt_r <= 3'h0;
            if (is_read_r) begin
              tx_r <= rd_now;
              sda_oe_r <= ~rd_now[7];
              ptr_r <= ptr_r + 8'h01;
              state_r <= ST_RD;
            end else begin
              sda_oe_r <= 1'b0;
              state_r <= ST_WR;
            end
          end
          ST_RD: begin
            if (cnt_r == 3'h0) begin
              sda_oe_r <= 1'b0;
              state_r <= ST_RACK;
            end else begin
              sda_oe_r <= ~tx_r[6];
              tx_r <= {tx_r[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            // Host ack continues the burst, a nack ends it
            if (is_read_r) begin
              tx_r <= rd_now;
              sda_oe_r <= ~rd_now[7];
              ptr_r <= ptr_r + 8'h01;
              cnt_r <= 3'h0;
              state_r <= ST_RD;
            end else begin
              state_r <= ST_WAIT;
            end
          end
          default: begin
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `REG_COUNT; g = g + 1) begin : bank
      // Folded to a constant so the reset branch loads a plain value
      localparam [7:0] RST_V = reset_value(g);
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          bank_r[g] <= RST_V;
        end else if (wr_en_r && (wr_idx_r == g)) begin
          bank_r[g] <= wr_data_r;
        end
      end
    end
  endgenerate

  assign sda_out = sda_out_r;
  assign sda_oe = sda_oe_r;
  assign spread_step_size = {bank_r[2], bank_r[0]};
  assign spread_step_delta = bank_r[1];
  assign spread_period = {bank_r[4][7:6], bank_r[3]};
  assign spread_modulation_on = bank_r[4][`BIT_SPREAD_ON];
  assign filter_res_100k_add = bank_r[4][`BIT_RES_100K];
  assign filter_res_50k_add = bank_r[4][`BIT_RES_50K];
  assign filter_res_25k_add = bank_r[4][`BIT_RES_25K];
  assign filter_res_12k5_add = bank_r[4][`BIT_RES_12K5];
  assign filter_res_6k_only = bank_r[4][`BIT_RES_6K];
  assign pump_gain_x16 = bank_r[5][`BIT_GAIN_X16];
  assign pump_gain_x8 = bank_r[5][`BIT_GAIN_X8];
  assign pump_gain_x4 = bank_r[5][`BIT_GAIN_X4];
  assign pump_gain_x2 = bank_r[5][`BIT_GAIN_X2];
  assign pump_gain_x1 = bank_r[5][`BIT_GAIN_X1];
  assign pump_scale_div24 = bank_r[5][`BIT_SCALE_DIV24];
  assign pump_scale_div3 = bank_r[5][`BIT_SCALE_DIV3];
  assign reference_current_select = bank_r[5][`BIT_IREF_SEL];
  assign reference_doubler_on = bank_r[6][`BIT_DOUBLER];
  assign reference_bypass_by_one = bank_r[6][`BIT_BYPASS_1];
  assign reference_bypass_by_two = bank_r[6][`BIT_BYPASS_2];
  // Range 3..64 is not enforced; the stored value is passed on as written
  assign reference_divide_value = bank_r[6][4:0];
  assign third_output_divide = bank_r[7][7:4];
  assign fourth_output_divide = bank_r[7][3:0];
  assign fine_spread_resolution = bank_r[8][`BIT_FINE_RES];
  assign second_synth_ref_source = bank_r[8][`BIT_REF_SRC];
  assign third_synth_run = bank_r[8][`BIT_RUN3];
  assign second_synth_run = bank_r[8][`BIT_RUN2];
  assign first_synth_run = bank_r[8][`BIT_RUN1];
  assign third_synth_lock_use = bank_r[8][`BIT_LOCK3];
  assign second_synth_lock_use = bank_r[8][`BIT_LOCK2];
  assign first_synth_lock_use = bank_r[8][`BIT_LOCK1];

endmodule // pll_config_register_bank

// File: verilog/pll_cfg_regs.vh
`ifndef PLL_CFG_REGS_VH
`define PLL_CFG_REGS_VH
// Byte offsets on the two-wire bus
`define OFS_STEP_LOW 8'h14
`define OFS_STEP_DELTA 8'h15
`define OFS_STEP_HIGH 8'h16
`define OFS_PERIOD_LOW 8'h17
`define OFS_PERIOD_HIGH_FILTER 8'h18
`define OFS_PUMP 8'h19
`define OFS_REF_DIV 8'h1a
`define OFS_OUT_DIV 8'h1b
`define OFS_SYNTH_OP 8'h1c
`define REG_COUNT 9
// Power-up values
`define RST_STEP_LOW 8'h00
`define RST_STEP_DELTA 8'h00
`define RST_STEP_HIGH 8'h00
`define RST_PERIOD_LOW 8'h00
`define RST_PERIOD_HIGH_FILTER 8'h0e
`define RST_PUMP 8'h14
`define RST_REF_DIV 8'h19
`define RST_OUT_DIV 8'h43
`define RST_SYNTH_OP 8'h3f
// Field positions
`define BIT_SPREAD_ON 5
`define BIT_RES_100K 4
`define BIT_RES_50K 3
`define BIT_RES_25K 2
`define BIT_RES_12K5 1
`define BIT_RES_6K 0
`define BIT_GAIN_X16 7
`define BIT_GAIN_X8 6
`define BIT_GAIN_X4 5
`define BIT_GAIN_X2 4
`define BIT_GAIN_X1 3
`define BIT_SCALE_DIV24 2
`define BIT_SCALE_DIV3 1
`define BIT_IREF_SEL 0
`define BIT_DOUBLER 7
`define BIT_BYPASS_1 6
`define BIT_BYPASS_2 5
`define BIT_FINE_RES 7
`define BIT_REF_SRC 6
`define BIT_RUN3 5
`define BIT_LOCK3 4
`define BIT_RUN2 3
`define BIT_LOCK2 2
`define BIT_RUN1 1
`define BIT_LOCK1 0
// Bus slave address, arbitrary value
`define DEV_ADDR_DEFAULT 7'h5a
`endif

// File: dv/pll_cfg_checker.sv
`timescale 1ns/100ps
module pll_cfg_checker (
  input wire clk, input wire rstn, input wire scl_in, input wire sda_in,
  input wire sda_out, input wire sda_oe,
  input wire [15:0] spread_step_size, input wire [9:0] spread_period,
  input wire [4:0] reference_divide_value,
  input wire [3:0] third_output_divide, input wire [3:0] fourth_output_divide
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire [38:0] fv = {spread_step_size, spread_period, reference_divide_value,
    third_output_divide, fourth_output_divide};
  sequence s_start;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  a_reset_values: assert property ($rose(rstn) |-> fv == {16'h0000, 10'h000, 5'h19, 4'h4, 4'h3})
    else $error("fields not at power-up values");
  a_drive_low_only: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  // Commit follows a bus clock fall, never an idle bus
  a_field_change_time: assert property ($changed(fv) |-> !$past(scl_in, 2) && !$past(scl_in, 3))
    else $error("field changed away from a byte end");
  a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data drive began with clock high");
  a_oe_stable_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data drive moved with clock high");
  a_stop_release: assert property (s_stop |-> !sda_oe [*4])
    else $error("data driven after stop");
  a_start_quiet: assert property (s_start |-> !sda_oe [*8])
    else $error("data driven right after start");
  a_start_fields: assert property (s_start |-> $stable(fv) [*4])
    else $error("fields moved at start");
endmodule // pll_cfg_checker
bind pll_config_register_bank pll_cfg_checker chk (.clk(clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .spread_step_size(spread_step_size), .spread_period(spread_period),
  .reference_divide_value(reference_divide_value), .third_output_divide(third_output_divide),
  .fourth_output_divide(fourth_output_divide));

// File: dv/twi_host.sv
`timescale 1ns/100ps
module twi_host (
  input wire clk,
  input wire sda_line,
  output logic scl,
  output logic sda_h
);
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves only while clock is low, five cycles clear of each edge
  task automatic put(input logic b, output logic r);
    sda_h <= b;
    wt(5);
    scl <= 1'b1;
    wt(5);
    r = sda_line;
    scl <= 1'b0;
    wt(5);
  endtask
  task automatic start();
    sda_h <= 1'b1;
    wt(5);
    scl <= 1'b1;
    wt(5);
    sda_h <= 1'b0;
    wt(5);
    scl <= 1'b0;
    wt(5);
  endtask
  task automatic stop();
    sda_h <= 1'b0;
    wt(5);
    scl <= 1'b1;
    wt(5);
    sda_h <= 1'b1;
    wt(5);
  endtask
  task automatic xb(input logic [7:0] d, input logic hb, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--) put(d[i], q[i]);
    put(hb, nak);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d [9], input int n,
    output logic nak);
    logic [7:0] q;
    logic k;
    start();
    xb({a, 1'b0}, 1'b1, q, nak);
    xb(p, 1'b1, q, k);
    for (int i = 0; i < n; i++) xb(d[i], 1'b1, q, k);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n, output logic [7:0] d [9]);
    logic [7:0] q;
    logic k;
    start();
    xb({a, 1'b0}, 1'b1, q, k);
    xb(p, 1'b1, q, k);
    start();
    xb({a, 1'b1}, 1'b1, q, k);
    for (int i = 0; i < n; i++) xb(8'hff, i == n - 1, d[i], k);
    stop();
  endtask
endmodule // twi_host

// File: dv/pll_config_register_bank_test.sv
`timescale 1ns/100ps
`include "pll_cfg_regs.vh"
module pll_config_register_bank_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wire scl;
  wire sda_h;
  wire sda_out;
  wire sda_oe;
  wire [71:0] f;
  wire sda_line = sda_h & (sda_oe ? sda_out : 1'b1);
  int failures = 0;
  int n_tests = 0;
  logic [7:0] rst_v [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0e, 8'h14, 8'h19, 8'h43, 8'h3f};
  logic [7:0] pat [9] = '{8'ha5, 8'h3c, 8'h96, 8'h5a, 8'hc3, 8'h69, 8'h0f, 8'he1, 8'h78};
  logic [7:0] cur [9];
  logic [7:0] got [9];
  logic nak;
  always #5 clk = ~clk;
  twi_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_h(sda_h));
  pll_config_register_bank dut (
    .clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .spread_step_size(f[71:56]), .spread_step_delta(f[55:48]), .spread_period(f[47:38]),
    .spread_modulation_on(f[37]), .filter_res_100k_add(f[36]), .filter_res_50k_add(f[35]),
    .filter_res_25k_add(f[34]), .filter_res_12k5_add(f[33]), .filter_res_6k_only(f[32]),
    .pump_gain_x16(f[31]), .pump_gain_x8(f[30]), .pump_gain_x4(f[29]), .pump_gain_x2(f[28]),
    .pump_gain_x1(f[27]), .pump_scale_div24(f[26]), .pump_scale_div3(f[25]),
    .reference_current_select(f[24]), .reference_doubler_on(f[23]), .reference_bypass_by_one(f[22]),
    .reference_bypass_by_two(f[21]), .reference_divide_value(f[20:16]), .third_output_divide(f[15:12]),
    .fourth_output_divide(f[11:8]), .fine_spread_resolution(f[7]), .second_synth_ref_source(f[6]),
    .third_synth_run(f[5]), .third_synth_lock_use(f[4]), .second_synth_run(f[3]),
    .second_synth_lock_use(f[2]), .first_synth_run(f[1]), .first_synth_lock_use(f[0]));
  // Registers 14h..1Ch laid out in the order of the field vector
  function automatic logic [71:0] fx(input logic [7:0] r [9]);
    return {r[2], r[0], r[1], r[4][7:6], r[3], r[4][5:0], r[5], r[6], r[7], r[8]};
  endfunction
  task automatic chk_f(input logic [71:0] e);
    n_tests++;
    if (f !== e) begin
      failures++;
      $display("Error %0t: fields %h expected %h", $time, f, e);
    end
  endtask
  task automatic chk_b(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error %0t: read %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    $display("Error %0t: run did not complete", $time);
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    chk_f(fx(rst_v));
    host.rd(`DEV_ADDR_DEFAULT, 8'h14, 9, got);
    for (int i = 0; i < 9; i++) chk_b(got[i], rst_v[i]);
    $display("test power_up done");
    // Pattern then its inverse, so every field bit is set and cleared
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 9; i++) cur[i] = k ? ~pat[i] : pat[i];
      host.wr(`DEV_ADDR_DEFAULT, 8'h14, cur, 9, nak);
      chk_b({7'h00, nak}, 8'h00);
      chk_f(fx(cur));
      host.rd(`DEV_ADDR_DEFAULT, 8'h14, 9, got);
      for (int i = 0; i < 9; i++) chk_b(got[i], cur[i]);
    end
    $display("test pattern done");
    got[0] = 8'h96;
    got[1] = 8'h77;
    cur[8] = 8'h96;
    host.wr(`DEV_ADDR_DEFAULT, 8'h1c, got, 2, nak);
    chk_f(fx(cur));
    host.rd(`DEV_ADDR_DEFAULT, 8'h1b, 3, got);
    chk_b(got[0], cur[7]);
    chk_b(got[1], 8'h96);
    chk_b(got[2], 8'h00);
    host.rd(`DEV_ADDR_DEFAULT, 8'h13, 1, got);
    chk_b(got[0], 8'h00);
    $display("test unmapped done");
    host.wr(`DEV_ADDR_DEFAULT ^ 7'h01, 8'h14, pat, 9, nak);
    chk_b({7'h00, nak}, 8'h01);
    chk_f(fx(cur));
    $display("test foreign_address done");
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk_f(fx(rst_v));
    rstn <= 1'b1;
    host.rd(`DEV_ADDR_DEFAULT, 8'h18, 1, got);
    chk_b(got[0], 8'h0e);
    $display("test mid_reset done");
    tally_and_finish();
  end
endmodule // pll_config_register_bank_test
